// ### design/mcb_pkg.sv
/*
  Constants, offsets and field positions of the controller's register bank:
  interrupt enables, lost packet counter, EEPROM serial port, timer, wake-up seed.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
// Functional notes
// - descriptor-unavailable irq needs bit2 and normal master
// - tx-stopped irq needs bit1 and abnormal master
// - tx-done irq needs bit0 and normal master
// - count dropped packets, clear on read
// - overflow flag bit16 held until read
// - EEPROM read needs read enable and select
// - EEPROM write needs write enable and select
// - returned EEPROM bit at bit3, resets 1
// - bit2 drives data toward EEPROM, resets 1
// - bit0 drives chip select, resets 1
// - timer loads bits 15:0, decrements every 204us
// - bit16 selects continuous timer mode
// - bit30 selects CRC seed 0000h or FFFFh
// - bit16 normal master, bit15 abnormal master
// - timer irq needs bit11 and abnormal master
package mcb_pkg;
  // ************
  // register map
  // ************
  localparam logic [7:0] OFF_IER = 8'h38;
  localparam logic [7:0] OFF_LPC = 8'h40;
  localparam logic [7:0] OFF_SPR = 8'h48;
  localparam logic [7:0] OFF_TMR = 8'h58;
  localparam logic [7:0] OFF_WCSR = 8'h68;
  localparam logic [7:0] OFF_ISR = 8'h70;
  localparam logic [7:0] OFF_IMR = 8'h74;
  // ************
  // fields
  // ************
  localparam int BIT_TX_DONE_EN = 0;
  localparam int BIT_TX_STOPPED_EN = 1;
  localparam int BIT_TX_DESC_EN = 2;
  localparam int BIT_TIMER_EN = 11;
  localparam int BIT_ABNORMAL_MASTER = 15;
  localparam int BIT_NORMAL_MASTER = 16;
  localparam logic [31:0] IER_WMASK = 32'h0001_8807;
  localparam int BIT_LPC_OVF = 16;
  localparam int BIT_EE_READ_EN = 14;
  localparam int BIT_EE_WRITE_EN = 13;
  localparam int BIT_EE_SELECT = 11;
  localparam int BIT_EE_RETURN = 3;
  localparam int BIT_EE_SEND = 2;
  localparam int BIT_EE_CLK = 1;
  localparam int BIT_EE_CS = 0;
  localparam logic [31:0] SPR_WMASK = 32'h0000_6807;
  localparam logic [31:0] SPR_RESET = 32'h0000_000F;
  localparam int BIT_TMR_CONT = 16;
  localparam logic [31:0] TMR_WMASK = 32'h0001_FFFF;
  localparam int BIT_SEED_SEL = 30;
  localparam logic [15:0] SEED_ZERO = 16'h0000;
  localparam logic [15:0] SEED_ONES = 16'hFFFF;
  // status/mask event positions
  localparam int EV_TX_DONE = 0;
  localparam int EV_TX_STOPPED = 1;
  localparam int EV_TX_DESC = 2;
  localparam int EV_TIMER = 3;
  localparam int EV_LPC_OVF = 4;
  localparam int N_EV = 5;
  // ************
  // timing
  // ************
  localparam int CLK_FREQ_MHZ = 200;
  localparam int TIMER_PERIOD_US = 204;
  localparam int TIMER_TICK_CYCLES = TIMER_PERIOD_US * CLK_FREQ_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mcb_pkg

// ### design/mcb_timer_if.sv
/*
  Connection between the register bank and the count-down timer.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface mcb_timer_if;
  logic load;
  logic [15:0] value;
  logic cont;
  logic tick;
  logic [15:0] count;
  logic expired;
  modport ctrl (output load, output value, output cont, output tick, input count, input expired);
  modport timer (input load, input value, input cont, input tick, output count, output expired);
endinterface : mcb_timer_if

// ### design/mcb_timer.sv
/*
  16-bit count-down general-purpose timer, one step per tick pulse.
  Assumes tick is a one-cycle enable from a divider on the same clock.
*/
`timescale 1ns/1ps
module mcb_timer
  import mcb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  mcb_timer_if.timer tif
);
  logic [15:0] count_q;
  logic expired_q;

  // ************
  // counter
  // ************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 16'h0000;
    end else if (tif.load) begin
      count_q <= tif.value;
    end else if (tif.tick && count_q != 16'h0000) begin
      if (count_q == 16'h0001 && tif.cont) begin
        count_q <= tif.value;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= !tif.load && tif.tick && count_q == 16'h0001;
    end
  end

  assign tif.count = count_q;
  assign tif.expired = expired_q;

  // ************
  // checks
  // ************
  property p_tmr_dec;
    @(posedge aclk) disable iff (!aresetn)
      (tif.tick && !tif.load && count_q > 16'h0001) |=> count_q == $past(count_q) - 16'h0001;
  endproperty
  a_tmr_dec: assert property (p_tmr_dec) else $error("timer did not step down");

  property p_tmr_exp;
    @(posedge aclk) disable iff (!aresetn)
      (tif.tick && !tif.load && count_q == 16'h0001) |=>
        expired_q && (count_q == ($past(tif.cont) ? $past(tif.value) : 16'h0000));
  endproperty
  a_tmr_exp: assert property (p_tmr_exp) else $error("timer expiry wrong");

  property p_tmr_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!tif.load && count_q == 16'h0000) |=> count_q == 16'h0000 && !expired_q;
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("stopped timer moved");
endmodule : mcb_timer

// ### design/mcb_csr_bank.sv
/*
  Register bank: interrupt enables, lost packet counter, EEPROM bit-bang port,
  general-purpose timer and wake-up CRC seed select, on an AXI4-Lite slave.
  Assumes event inputs are one-cycle pulses on aclk; the EEPROM return pin is asynchronous.
*/
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module mcb_csr_bank
  import mcb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TIMER_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_done_evt,
  input wire logic tx_stopped_evt,
  input wire logic tx_desc_unavail_evt,
  input wire logic rx_drop_evt,
  output logic eeprom_chip_select,
  output logic eeprom_clk,
  output logic eeprom_serial_send,
  input wire logic eeprom_serial_return,
  output logic [15:0] crc_seed,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    is_mapped = (w == OFF_IER) || (w == OFF_LPC) || (w == OFF_SPR) || (w == OFF_TMR) ||
                (w == OFF_WCSR) || (w == OFF_ISR) || (w == OFF_IMR);
  endfunction : is_mapped

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  mcb_timer_if tif ();

  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] ier_q;
  logic [15:0] lpc_q;
  logic lpc_ovf_q;
  logic [31:0] spr_q;
  logic [15:0] tmr_value_q;
  logic tmr_cont_q;
  logic tmr_load_q;
  logic seed_sel_q;
  logic [N_EV-1:0] isr_q;
  logic [N_EV-1:0] imr_q;
  logic irq_q;
  logic ret_s1_q;
  logic ret_s2_q;
  logic ee_cs_q;
  logic ee_clk_q;
  logic ee_send_q;
  logic [15:0] seed_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;

  logic do_write;
  logic ar_take;
  logic [7:0] wa;
  logic [31:0] wm;
  logic [31:0] wbits;
  logic rd_lpc;
  logic ee_rd_ok;
  logic ee_wr_ok;
  logic normal_en;
  logic abnormal_en;
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] gate;

  // ************
  // bus handshake
  // ************
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_arready = !rvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign ar_take = s_axi_arvalid && !rvalid_q;
  assign wa = {aw_addr_q[7:2], 2'b00};
  assign wm = strb_mask(w_strb_q);
  assign wbits = w_data_q & wm;
  assign rd_lpc = ar_take && {s_axi_araddr[7:2], 2'b00} == OFF_LPC;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && !aw_hold_q) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_hold_q) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        OFF_IER: rdata_q <= ier_q;
        OFF_LPC: rdata_q <= {15'h0000, lpc_ovf_q, lpc_q};
        OFF_SPR: rdata_q <= spr_q;
        OFF_TMR: rdata_q <= {15'h0000, tmr_cont_q, tif.count};
        OFF_WCSR: rdata_q <= {1'b0, seed_sel_q, 30'h0000_0000};
        OFF_ISR: rdata_q <= {{(32 - N_EV){1'b0}}, isr_q};
        OFF_IMR: rdata_q <= {{(32 - N_EV){1'b0}}, imr_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ************
  // interrupt enables and wake-up seed
  // ************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ier_q <= 32'h0000_0000;
    end else if (do_write && wa == OFF_IER) begin
      ier_q <= ((ier_q & ~wm) | wbits) & IER_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seed_sel_q <= 1'b0;
    end else if (do_write && wa == OFF_WCSR && w_strb_q[3]) begin
      seed_sel_q <= w_data_q[BIT_SEED_SEL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seed_q <= SEED_ZERO;
    end else begin
      seed_q <= seed_sel_q ? SEED_ONES : SEED_ZERO;
    end
  end
  assign crc_seed = seed_q;

  // ************
  // lost packet counter
  // ************
  // a drop in the cycle of the clearing read counts as the first of the new window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpc_q <= 16'h0000;
    end else if (rd_lpc) begin
      lpc_q <= {15'h0000, rx_drop_evt};
    end else if (rx_drop_evt) begin
      lpc_q <= lpc_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpc_ovf_q <= 1'b0;
    end else if (rx_drop_evt && lpc_q == 16'hFFFF && !rd_lpc) begin
      lpc_ovf_q <= 1'b1;
    end else if (rd_lpc) begin
      lpc_ovf_q <= 1'b0;
    end
  end

  // ************
  // EEPROM serial port
  // ************
  assign ee_rd_ok = spr_q[BIT_EE_READ_EN] && spr_q[BIT_EE_SELECT];
  assign ee_wr_ok = spr_q[BIT_EE_WRITE_EN] && spr_q[BIT_EE_SELECT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ret_s1_q <= 1'b1;
      ret_s2_q <= 1'b1;
    end else begin
      ret_s1_q <= eeprom_serial_return;
      ret_s2_q <= ret_s1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spr_q <= SPR_RESET;
    end else begin
      if (do_write && wa == OFF_SPR) begin
        spr_q[15:0] <= (spr_q[15:0] & ~(wm[15:0] & SPR_WMASK[15:0])) | (wbits[15:0] & SPR_WMASK[15:0]);
      end
      if (ee_rd_ok) begin
        spr_q[BIT_EE_RETURN] <= ret_s2_q;
      end
    end
  end

  // pins idle with chip select low when the port is not selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_cs_q <= 1'b0;
      ee_clk_q <= 1'b0;
      ee_send_q <= 1'b0;
    end else begin
      ee_cs_q <= spr_q[BIT_EE_SELECT] && spr_q[BIT_EE_CS];
      ee_clk_q <= spr_q[BIT_EE_SELECT] && spr_q[BIT_EE_CLK];
      ee_send_q <= ee_wr_ok && spr_q[BIT_EE_SEND];
    end
  end
  assign eeprom_chip_select = ee_cs_q;
  assign eeprom_clk = ee_clk_q;
  assign eeprom_serial_send = ee_send_q;

  // ************
  // timer
  // ************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_value_q <= 16'h0000;
      tmr_cont_q <= 1'b0;
      tmr_load_q <= 1'b0;
    end else begin
      tmr_load_q <= do_write && wa == OFF_TMR && (w_strb_q[1] || w_strb_q[0]);
      if (do_write && wa == OFF_TMR) begin
        tmr_value_q <= (tmr_value_q & ~wm[15:0]) | wbits[15:0];
        if (w_strb_q[2]) begin
          tmr_cont_q <= w_data_q[BIT_TMR_CONT];
        end
      end
    end
  end

  // divider restarts only at reset, so the first step after a load comes within one period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
      tick_q <= 1'b0;
    end
  end

  assign tif.load = tmr_load_q;
  assign tif.value = tmr_value_q;
  assign tif.cont = tmr_cont_q;
  assign tif.tick = tick_q;

  mcb_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tif(tif)
  );

  // ************
  // interrupt status and mask
  // ************
  assign normal_en = ier_q[BIT_NORMAL_MASTER];
  assign abnormal_en = ier_q[BIT_ABNORMAL_MASTER];
  assign ev = {lpc_ovf_q == 1'b0 && rx_drop_evt && lpc_q == 16'hFFFF && !rd_lpc, tif.expired,
               tx_desc_unavail_evt, tx_stopped_evt, tx_done_evt};
  assign gate = {1'b1,
                 ier_q[BIT_TIMER_EN] && abnormal_en,
                 ier_q[BIT_TX_DESC_EN] && normal_en,
                 ier_q[BIT_TX_STOPPED_EN] && abnormal_en,
                 ier_q[BIT_TX_DONE_EN] && normal_en};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isr_q <= '0;
    end else if (do_write && wa == OFF_ISR) begin
      isr_q <= (isr_q & ~wbits[N_EV-1:0]) | ev;
    end else begin
      isr_q <= isr_q | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imr_q <= '0;
    end else if (do_write && wa == OFF_IMR) begin
      imr_q <= (imr_q & ~wm[N_EV-1:0]) | wbits[N_EV-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(isr_q & imr_q & gate);
    end
  end
  assign irq = irq_q;

  // ************
  // checks
  // ************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_lpc_inc;
    (rx_drop_evt && !rd_lpc) |=> lpc_q == $past(lpc_q) + 16'h0001;
  endproperty
  a_lpc_inc: assert property (p_lpc_inc) else $error("lost count did not step");

  property p_lpc_clr;
    (rd_lpc && !rx_drop_evt) |=> lpc_q == 16'h0000 && !lpc_ovf_q;
  endproperty
  a_lpc_clr: assert property (p_lpc_clr) else $error("lost count not cleared by read");

  property p_lpc_ovf;
    (rx_drop_evt && lpc_q == 16'hFFFF && !rd_lpc) |=> lpc_ovf_q ##1 (lpc_ovf_q || $past(rd_lpc));
  endproperty
  a_lpc_ovf: assert property (p_lpc_ovf) else $error("overflow flag lost");

  property p_ee_ret;
    !ee_rd_ok |=> $stable(spr_q[BIT_EE_RETURN]);
  endproperty
  a_ee_ret: assert property (p_ee_ret) else $error("return bit moved while read disabled");

  property p_ee_send;
    !ee_wr_ok |=> !eeprom_serial_send;
  endproperty
  a_ee_send: assert property (p_ee_send) else $error("data sent while write disabled");

  property p_ee_cs;
    (spr_q[BIT_EE_SELECT] && spr_q[BIT_EE_CS]) [*2] |-> eeprom_chip_select;
  endproperty
  a_ee_cs: assert property (p_ee_cs) else $error("chip select not following bit");

  property p_irq_gate;
    (!normal_en && !abnormal_en && !(isr_q[EV_LPC_OVF] && imr_q[EV_LPC_OVF])) |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without master enable");

  property p_seed;
    seed_sel_q |-> ##1 (crc_seed == SEED_ONES || !$past(seed_sel_q, 1));
  endproperty
  a_seed: assert property (p_seed) else $error("crc seed wrong");
endmodule : mcb_csr_bank

// ### tb/mcb_ee_model.sv
/*
  Behavioural serial EEPROM on the bit-banged port: shifts bits in on each rising
  clock while selected and shifts a fixed pattern back out.
  Assumes its pins are driven by the register bank's registered outputs.
*/
`timescale 1ns/1ps
module mcb_ee_model #(
  parameter logic [7:0] PATTERN = 8'hA5
) (
  input wire logic eeprom_chip_select,
  input wire logic eeprom_clk,
  input wire logic eeprom_serial_send,
  output logic eeprom_serial_return,
  output logic [7:0] rx_q
);
  // ************
  // shift logic
  // ************
  logic [2:0] idx_q = 3'h7;
  logic [7:0] sh_q = 8'h00;
  logic ret_q = 1'b1;
  logic cs_q = 1'b0;
  assign eeprom_serial_return = ret_q;
  assign rx_q = sh_q;
  // one process owns the pin, so select edges and clock edges never race
  always @(eeprom_chip_select or posedge eeprom_clk) begin
    if (eeprom_chip_select === 1'b1 && cs_q !== 1'b1) begin
      idx_q <= 3'h7;
      ret_q <= PATTERN[7];
    end else if (eeprom_chip_select !== 1'b1 && cs_q === 1'b1) begin
      // released line flips so a stale level never passes for data
      ret_q <= ~ret_q;
    end else if (eeprom_clk === 1'b1 && eeprom_chip_select === 1'b1) begin
      sh_q <= {sh_q[6:0], eeprom_serial_send};
      ret_q <= PATTERN[idx_q - 3'h1];
      idx_q <= idx_q - 3'h1;
    end
    cs_q = eeprom_chip_select;
  end
endmodule : mcb_ee_model

// ### tb/tb.sv
/*
  Self-checking bench of the register bank: bus, interrupts, lost packet
  counter, EEPROM port, timer and CRC seed select.
  Assumes the EEPROM model beside it and a timer tick cut to 8 cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
$display("[FAIL] %s exp=%h got=%h", nm, ex, got); end end
module tb;
  import mcb_pkg::*;
  localparam logic [7:0] EE_PAT = 8'hA5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1;
  logic [3:0] evt = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic eeprom_chip_select, eeprom_clk, eeprom_serial_send, eeprom_serial_return;
  logic [15:0] crc_seed;
  logic [7:0] ee_rx;
  int errors = 0;
  int n_tests = 0;

  always #2.5 aclk = ~aclk;

  mcb_csr_bank #(.TICK_CYCLES(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_done_evt(evt[0]), .tx_stopped_evt(evt[1]), .tx_desc_unavail_evt(evt[2]), .rx_drop_evt(evt[3]),
    .eeprom_chip_select, .eeprom_clk, .eeprom_serial_send, .eeprom_serial_return, .crc_seed, .irq);
  mcb_ee_model #(.PATTERN(EE_PAT)) i_ee (.eeprom_chip_select, .eeprom_clk, .eeprom_serial_send,
    .eeprom_serial_return, .rx_q(ee_rx));

  // ************
  // bus tasks
  // ************
  // no cycle limit here: only the watchdog ends a wait for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    `CHK("rresp", er, s_axi_rresp)
  endtask : rd

  task automatic ier_irq(input logic [31:0] ier, input logic ex);
    wr(OFF_IER, ier, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("irq", ex, irq)
  endtask : ier_irq

  task automatic wait_irq(output int n);
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
  endtask : wait_irq

  // ************
  // scenarios
  // ************
  task automatic t_reset();
    logic [7:0] a[5] = '{OFF_IER, OFF_LPC, OFF_SPR, OFF_TMR, OFF_WCSR};
    logic [31:0] e[5] = '{32'h0, 32'h0, SPR_RESET, 32'h0, 32'h0};
    logic [31:0] v;
    int i;
    for (i = 0; i < 5; i++) begin
      rd(a[i], RESP_OKAY, v);
      `CHK("rst_val", e[i], v)
    end
    `CHK("seed_rst", SEED_ZERO, crc_seed)
    `CHK("cs_rst", 1'b0, eeprom_chip_select)
    rd(8'h3C, RESP_SLVERR, v);
    `CHK("unmapped", 32'h0, v)
    wr(8'h3C, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFF_IER, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_IER, RESP_OKAY, v);
    `CHK("ier_mask", IER_WMASK, v)
    wr(OFF_IER, 32'h0, RESP_OKAY);
    $display("done t_reset");
  endtask : t_reset

  task automatic t_irq();
    logic [31:0] m;
    logic [31:0] v;
    int i;
    for (i = 0; i < 3; i++) begin
      m = (i == 1) ? 32'h0000_8000 : 32'h0001_0000;
      wr(OFF_IMR, 32'h1 << i, RESP_OKAY);
      evt[i] <= 1'b1;
      @(posedge aclk);
      evt[i] <= 1'b0;
      ier_irq(32'h1 << i, 1'b0);
      ier_irq((m ^ 32'h0001_8000) | (32'h1 << i), 1'b0);
      ier_irq(m | (32'h1 << i), 1'b1);
      ier_irq(m, 1'b0);
      rd(OFF_ISR, RESP_OKAY, v);
      `CHK("isr_set", 1'b1, v[i])
      wr(OFF_ISR, 32'h1 << i, RESP_OKAY);
      rd(OFF_ISR, RESP_OKAY, v);
      `CHK("isr_clr", 1'b0, v[i])
    end
    wr(OFF_IMR, 32'h0, RESP_OKAY);
    wr(OFF_IER, 32'h0, RESP_OKAY);
    $display("done t_irq");
  endtask : t_irq

  task automatic t_ee();
    logic [31:0] v;
    logic b;
    int j;
    wr(OFF_SPR, 32'h0805, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("ee_send_off", 1'b0, eeprom_serial_send)
    `CHK("ee_cs", 1'b1, eeprom_chip_select)
    wr(OFF_SPR, 32'h0004, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("ee_cs_off", 1'b0, eeprom_chip_select)
    for (j = 0; j < 4; j++) begin
      b = (j != 1);
      wr(OFF_SPR, {29'h0D00, b, 2'h1}, RESP_OKAY);
      repeat (4) @(posedge aclk);
      `CHK("ee_clk_lo", 1'b0, eeprom_clk)
      rd(OFF_SPR, RESP_OKAY, v);
      `CHK("ee_ret", EE_PAT[7 - j], v[3])
      wr(OFF_SPR, {29'h0D00, b, 2'h3}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("ee_clk", 1'b1, eeprom_clk)
      `CHK("ee_send", b, eeprom_serial_send)
    end
    // read enable off: the returned bit must stay frozen
    wr(OFF_SPR, 32'h2801, RESP_OKAY);
    wr(OFF_SPR, 32'h2803, RESP_OKAY);
    repeat (4) @(posedge aclk);
    rd(OFF_SPR, RESP_OKAY, v);
    `CHK("ee_ret_hold", EE_PAT[3], v[3])
    `CHK("ee_rx", 5'b10110, ee_rx[4:0])
    wr(OFF_SPR, SPR_RESET, RESP_OKAY);
    $display("done t_ee");
  endtask : t_ee

  task automatic t_timer();
    logic [31:0] v;
    int n;
    wr(OFF_IMR, 32'h8, RESP_OKAY);
    wr(OFF_IER, 32'h0800, RESP_OKAY);
    wr(OFF_TMR, 32'h1, RESP_OKAY);
    wait_irq(n);
    `CHK("tmr_gate", 1'b1, n == 200)
    wr(OFF_ISR, 32'h8, RESP_OKAY);
    wr(OFF_IER, 32'h8800, RESP_OKAY);
    wr(OFF_TMR, 32'h3, RESP_OKAY);
    wait_irq(n);
    `CHK("tmr_time", 1'b1, n >= 16 && n < 40)
    repeat (40) @(posedge aclk);
    rd(OFF_TMR, RESP_OKAY, v);
    `CHK("tmr_stop", 32'h0, v)
    wr(OFF_ISR, 32'h8, RESP_OKAY);
    wr(OFF_TMR, 32'h0001_0002, RESP_OKAY);
    wait_irq(n);
    wr(OFF_ISR, 32'h8, RESP_OKAY);
    wait_irq(n);
    `CHK("tmr_reload", 1'b1, n < 40)
    rd(OFF_TMR, RESP_OKAY, v);
    `CHK("tmr_cont", 1'b1, v[16] && v[15:0] != 16'h0)
    wr(OFF_TMR, 32'h0, RESP_OKAY);
    wr(OFF_ISR, 32'h8, RESP_OKAY);
    wr(OFF_IER, 32'h0, RESP_OKAY);
    wr(OFF_IMR, 32'h0, RESP_OKAY);
    $display("done t_timer");
  endtask : t_timer

  task automatic t_crc();
    logic [31:0] v;
    wr(OFF_WCSR, 32'h4000_0000, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("seed_ones", SEED_ONES, crc_seed)
    rd(OFF_WCSR, RESP_OKAY, v);
    `CHK("wcsr", 32'h4000_0000, v)
    wr(OFF_WCSR, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("seed_zero", SEED_ZERO, crc_seed)
    $display("done t_crc");
  endtask : t_crc

  task automatic t_lpc();
    logic [31:0] v;
    evt[3] <= 1'b1;
    repeat (3) @(posedge aclk);
    evt[3] <= 1'b0;
    rd(OFF_LPC, RESP_OKAY, v);
    `CHK("lpc_cnt", 32'h3, v)
    rd(OFF_LPC, RESP_OKAY, v);
    `CHK("lpc_rc", 32'h0, v)
    // a full wrap of the count sets the overflow flag
    evt[3] <= 1'b1;
    repeat (65536) @(posedge aclk);
    evt[3] <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(OFF_ISR, RESP_OKAY, v);
    `CHK("lpc_ovf_evt", 1'b1, v[EV_LPC_OVF])
    rd(OFF_LPC, RESP_OKAY, v);
    `CHK("lpc_ovf", 32'h0001_0000, v)
    rd(OFF_LPC, RESP_OKAY, v);
    `CHK("lpc_ovf_rc", 32'h0, v)
    $display("done t_lpc");
  endtask : t_lpc

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (80000) @(posedge aclk);
    errors++;
    $display("[FAIL] watchdog exp=done got=hang");
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_irq();
    t_ee();
    t_timer();
    t_crc();
    t_lpc();
    wrap_up();
  end
endmodule : tb
